// >>> design/motion_cmd_defines.svh
// register offsets, frame layout, codes and reset values of the command decoder
`ifndef MOTION_CMD_DEFINES_SVH
`define MOTION_CMD_DEFINES_SVH

// apb register byte offsets
`define OFS_FRAME_BYTE   8'h00
`define OFS_CONTROL      8'h04
`define OFS_REPLY_STATUS 8'h08
`define OFS_REPLY_VALUE  8'h0C
`define OFS_ACCUMULATOR  8'h10
`define OFS_MOVE         8'h14
`define OFS_ADDR_W       8

// control register fields
`define CTL_STANDALONE   0
`define CTL_FRAME_CLEAR  1

// reply status register fields
`define RST_VALID        8

// move register fields
`define MOV_INTERP       6
`define MOV_STORED_COORDINATE_TYPE_LSB    8

// frame layout: byte positions in arrival order
`define FRM_TARGET       3'h0
`define FRM_INSTR        3'h1
`define FRM_TYPE         3'h2
`define FRM_AXIS         3'h3
`define FRM_VAL3         3'h4
`define FRM_VAL2         3'h5
`define FRM_VAL1         3'h6
`define FRM_VAL0         3'h7
`define FRM_BODY_LEN     4'h8

// axis byte fields
`define AXB_MULTI        7
`define AXB_INTERP       6
`define AXIS_COUNT       6

// type byte of a move to a stored coordinate
`define MVT_STORED_COORDINATE_TYPE        8'h02

// bank numbers
`define BANK_MODULE      8'h00
`define BANK_USER        8'h02
`define BANK_IRQ         8'h03

// well-known parameter numbers
`define AP_ACTUAL_POS    8'h01
`define AP_MAX_SPEED     8'h04
`define GP_LINK_ADDR     8'h42

// reset value of the link address
`define LINK_ADDR_RESET  32'h0000_0001

`endif

// >>> design/motion_cmd_pkg.sv
// types shared by the motion command decoder
package motion_cmd_pkg;

  typedef enum logic [7:0] {
    CMD_MOVE_TO_POSITION = 8'h04,
    CMD_SET_AXIS_PARAM   = 8'h05,
    CMD_GET_AXIS_PARAM   = 8'h06,
    CMD_SET_GLOBAL_PARAM = 8'h09,
    CMD_GET_GLOBAL_PARAM = 8'h0A
  } cmd_code_t;

  typedef enum logic [7:0] {
    ST_BAD_CHECKSUM = 8'h01,
    ST_BAD_COMMAND  = 8'h02,
    ST_BAD_TYPE     = 8'h03,
    ST_BAD_VALUE    = 8'h04,
    ST_OK           = 8'h64
  } reply_status_t;

endpackage : motion_cmd_pkg

// >>> design/motion_param_command_decoder.sv
// binary command decoder: stored-coordinate moves and axis/global parameter access over apb
//
// Operation
// R1: instruction 4 type 2 moves selected axes to the stored coordinate in value.
// R2: single-axis move takes the axis byte as axis index 0 to 5.
// R3: axis bit 7 set: bits 0-5 mask, all flagged axes start, no interpolation.
// R4: axis bit 6 set: flagged axes move together as an interpolated group; the code interpolates only when bit 7 is clear.
// R5: host loads the coordinate by set, capture or copy before moving to it.
// R6: instruction 5 writes value into selected axis parameter, replies status 100.
// R7: axis parameters live in volatile storage only, lost at power off.
// R8: instruction 6 reads selected axis parameter, replies 100 with the value.
// R9: in standalone mode parameter reads also load the accumulator.
// R10: in direct mode axis parameter reads leave the accumulator unchanged.
// R11: instruction 9 writes value into global parameter of bank 0, 2 or 3.
// R12: bank 0 module settings, bank 2 user variables, bank 3 interrupt setup.
// R13: writes into bank 0 are committed to non-volatile storage automatically.
// R14: instruction 10 ignores value, loads accumulator, replies 100 with the parameter.
// R15: global parameter 66 of bank 0 is the serial link address.
// R16: axis parameter 4 is maximum positioning speed, 1 the actual position.
// R17: frame: address, instruction, type, axis/bank, value msb first, checksum.
// R18: checksum is the mod-256 sum of eight bytes, checked before execution.
`timescale 1ns/1ps
`include "motion_cmd_defines.svh"
`default_nettype none

module motion_param_command_decoder #(
  parameter int AXIS_PARAMS   = 16,
  parameter int GLOBAL_PARAMS = 128
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`OFS_ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [`AXIS_COUNT*32-1:0]   actual_position,
  output logic      [`AXIS_COUNT*32-1:0]   max_speed,
  output logic                             move_start,
  output logic      [`AXIS_COUNT-1:0]      move_axes,
  output logic                             move_interp,
  output logic      [31:0]                 move_stored_coordinate_type,
  output logic                             nv_commit,
  output logic      [7:0]                  nv_index,
  output logic      [31:0]                 nv_data
);

  localparam int AP_W = $clog2(AXIS_PARAMS);
  localparam int GP_W = $clog2(GLOBAL_PARAMS);

  // parameter numbers 1, 4 and 66 must exist
  if (AXIS_PARAMS <= int'(`AP_MAX_SPEED) || AXIS_PARAMS > 256) begin : g_bad_axis_params
    $error("AXIS_PARAMS out of range");
  end
  if (GLOBAL_PARAMS <= int'(`GP_LINK_ADDR) || GLOBAL_PARAMS > 256) begin : g_bad_global_params
    $error("GLOBAL_PARAMS out of range");
  end

  typedef struct packed {
    logic [3:0]                                    cnt;
    logic [7:0][7:0]                               frame;
    logic [7:0]                                    sum;
    logic                                          standalone;
    logic                                          rvalid;
    logic [7:0]                                    rstatus;
    logic [31:0]                                   rvalue;
    logic [31:0]                                   acc;
    logic                                          mstart;
    logic [`AXIS_COUNT-1:0]                        maxes;
    logic                                          interp;
    logic [31:0]                                   stored_coordinate_type;
    logic                                          nvc;
    logic [7:0]                                    nvidx;
    logic [31:0]                                   nvdata;
    logic [`AXIS_COUNT-1:0][AXIS_PARAMS-1:0][31:0] ap;
    logic [2:0][GLOBAL_PARAMS-1:0][31:0]           gp;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic       wr_en;
  logic       rd_en;
  logic       exec_hit;
  logic       exec_ok;
  logic [7:0] instr;
  logic [7:0] typ;
  logic [7:0] axb;
  logic [31:0] val;
  logic       axis_ok;
  logic       ap_ok;
  logic       gp_ok;
  logic       bank_ok;
  logic [1:0] bank_idx;
  logic [2:0] axis_idx;
  logic [`AXIS_COUNT-1:0] mask;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign instr = state_reg.frame[`FRM_INSTR];
  assign typ   = state_reg.frame[`FRM_TYPE];
  assign axb   = state_reg.frame[`FRM_AXIS];
  assign val   = {state_reg.frame[`FRM_VAL3], state_reg.frame[`FRM_VAL2],
                  state_reg.frame[`FRM_VAL1], state_reg.frame[`FRM_VAL0]};   // [R17]
  assign axis_idx = axb[2:0];
  assign axis_ok  = axb < 8'(`AXIS_COUNT);                                   // [R2]
  // nine bits so that a full table of 256 parameters still compares right
  assign ap_ok    = 9'(typ) < 9'(AXIS_PARAMS);
  assign gp_ok    = 9'(typ) < 9'(GLOBAL_PARAMS);
  // ninth byte is the checksum; the body is already latched
  assign exec_hit = wr_en && paddr == `OFS_FRAME_BYTE && state_reg.cnt == `FRM_BODY_LEN;
  // frames for another link address are dropped without any reply
  assign exec_ok  = exec_hit && state_reg.frame[`FRM_TARGET] == state_reg.gp[0][`GP_LINK_ADDR][7:0]
                    && pwdata[7:0] == state_reg.sum;                        // [R15] [R18]

  // bank byte to storage slot; other banks are refused
  always_comb begin
    bank_ok  = 1'b1;
    bank_idx = 2'h0;
    case (axb)
      `BANK_MODULE: bank_idx = 2'h0;                                         // [R12]
      `BANK_USER:   bank_idx = 2'h1;
      `BANK_IRQ:    bank_idx = 2'h2;
      default:      bank_ok  = 1'b0;                                         // [R11]
    endcase
  end

  // axis selection of a coordinate move
  always_comb begin
    mask = '0;
    if (axb[`AXB_MULTI] || axb[`AXB_INTERP])
      mask = axb[`AXIS_COUNT-1:0];                                           // [R3] [R4]
    else if (axis_ok)
      mask[axis_idx] = 1'b1;                                                 // [R2]
  end

  always_comb begin
    state_next        = state_reg;
    state_next.mstart = 1'b0;
    state_next.nvc    = 1'b0;
    if (rd_en && paddr == `OFS_REPLY_VALUE)
      state_next.rvalid = 1'b0;
    if (wr_en && paddr == `OFS_CONTROL) begin
      state_next.standalone = pwdata[`CTL_STANDALONE];
      if (pwdata[`CTL_FRAME_CLEAR]) begin
        state_next.cnt = '0;
        state_next.sum = '0;
      end
    end
    if (wr_en && paddr == `OFS_FRAME_BYTE) begin
      if (state_reg.cnt < `FRM_BODY_LEN) begin
        state_next.frame[state_reg.cnt[2:0]] = pwdata[7:0];                  // [R17]
        state_next.sum = state_reg.sum + pwdata[7:0];                        // [R18]
        state_next.cnt = state_reg.cnt + 4'h1;
      end else begin
        state_next.cnt = '0;
        state_next.sum = '0;
      end
    end
    if (exec_hit && state_reg.frame[`FRM_TARGET] == state_reg.gp[0][`GP_LINK_ADDR][7:0]) begin
      // a fresh reply wins over a clear in the same cycle
      state_next.rvalid  = 1'b1;
      state_next.rvalue  = '0;
      state_next.rstatus = motion_cmd_pkg::ST_OK;
      if (!exec_ok) begin
        state_next.rstatus = motion_cmd_pkg::ST_BAD_CHECKSUM;                // [R18]
      end else begin
        case (instr)
          motion_cmd_pkg::CMD_MOVE_TO_POSITION: begin
            // absolute and relative moves are not handled by this decoder
            if (typ != `MVT_STORED_COORDINATE_TYPE)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_TYPE;
            else if (mask == '0)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_VALUE;
            else begin
              // coordinate contents are the host's duty to load first     [R5]
              state_next.mstart = 1'b1;                                      // [R1]
              state_next.maxes  = mask;
              state_next.interp = !axb[`AXB_MULTI] && axb[`AXB_INTERP];      // [R3] [R4]
              state_next.stored_coordinate_type  = val;                                       // [R1]
            end
          end
          motion_cmd_pkg::CMD_SET_AXIS_PARAM: begin
            if (!ap_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_TYPE;
            else if (!axis_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_VALUE;
            else
              state_next.ap[axis_idx][typ[AP_W-1:0]] = val;                  // [R6] [R16]
          end
          motion_cmd_pkg::CMD_GET_AXIS_PARAM: begin
            if (!ap_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_TYPE;
            else if (!axis_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_VALUE;
            else begin
              if (typ == `AP_ACTUAL_POS)
                state_next.rvalue = actual_position[axis_idx*32 +: 32];      // [R16]
              else
                state_next.rvalue = state_reg.ap[axis_idx][typ[AP_W-1:0]];   // [R8]
              if (state_reg.standalone)
                state_next.acc = state_next.rvalue;                          // [R9] [R10]
            end
          end
          motion_cmd_pkg::CMD_SET_GLOBAL_PARAM: begin
            if (!gp_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_TYPE;
            else if (!bank_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_VALUE;
            else begin
              state_next.gp[bank_idx][typ[GP_W-1:0]] = val;                  // [R11]
              if (axb == `BANK_MODULE) begin
                state_next.nvc    = 1'b1;                                    // [R13]
                state_next.nvidx  = typ;
                state_next.nvdata = val;
              end
            end
          end
          motion_cmd_pkg::CMD_GET_GLOBAL_PARAM: begin
            if (!gp_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_TYPE;
            else if (!bank_ok)
              state_next.rstatus = motion_cmd_pkg::ST_BAD_VALUE;
            else begin
              // value field plays no part here
              state_next.rvalue = state_reg.gp[bank_idx][typ[GP_W-1:0]];    // [R14]
              state_next.acc    = state_next.rvalue;                         // [R14] [R9]
            end
          end
          default: state_next.rstatus = motion_cmd_pkg::ST_BAD_COMMAND;
        endcase
      end
    end
  end

  // reset stands for power loss: axis parameters come back cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;                                                       // [R7]
      state_reg.gp[0][`GP_LINK_ADDR] <= `LINK_ADDR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // register read mux; zero wait states, unmapped offsets answer with an error
  always_comb begin
    prdata  = '0;
    pslverr = 1'b0;
    case (paddr)
      `OFS_FRAME_BYTE:   prdata[3:0] = state_reg.cnt;
      `OFS_CONTROL:      prdata[`CTL_STANDALONE] = state_reg.standalone;
      `OFS_REPLY_STATUS: prdata[8:0] = {state_reg.rvalid, state_reg.rstatus};
      `OFS_REPLY_VALUE:  prdata = state_reg.rvalue;
      `OFS_ACCUMULATOR:  prdata = state_reg.acc;
      `OFS_MOVE:         prdata[`MOV_STORED_COORDINATE_TYPE_LSB +: 8] = state_reg.stored_coordinate_type[7:0];
      default:           pslverr = psel && penable;
    endcase
    if (paddr == `OFS_MOVE) begin
      prdata[`AXIS_COUNT-1:0] = state_reg.maxes;
      prdata[`MOV_INTERP]     = state_reg.interp;
    end
  end

  assign pready      = 1'b1;
  assign move_start  = state_reg.mstart;
  assign move_axes   = state_reg.maxes;
  assign move_interp = state_reg.interp;
  assign move_stored_coordinate_type  = state_reg.stored_coordinate_type;
  assign nv_commit   = state_reg.nvc;
  assign nv_index    = state_reg.nvidx;
  assign nv_data     = state_reg.nvdata;

  for (genvar g = 0; g < `AXIS_COUNT; g++) begin : g_speed
    assign max_speed[g*32 +: 32] = state_reg.ap[g][`AP_MAX_SPEED];           // [R16]
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  csum_reject_a: assert property (exec_hit && pwdata[7:0] != state_reg.sum                            // [R18]
      && state_reg.frame[`FRM_TARGET] == state_reg.gp[0][`GP_LINK_ADDR][7:0]
      |=> state_reg.rvalid && state_reg.rstatus == motion_cmd_pkg::ST_BAD_CHECKSUM && !move_start)
    else $error("bad checksum not rejected");

  single_move_a: assert property (exec_ok && instr == 8'h04 && typ == `MVT_STORED_COORDINATE_TYPE                     // [R2]
      && axb < 8'h06 |=> move_start && move_axes == 6'(1 << axis_idx) && !move_interp)
    else $error("single axis move wrong");

  multi_move_a: assert property (exec_ok && instr == 8'h04 && typ == `MVT_STORED_COORDINATE_TYPE && axb[7]             // [R3]
      && axb[5:0] != 6'h00 |=> move_start && move_axes == axb[5:0] && !move_interp)
    else $error("multi axis start wrong");

  interp_move_a: assert property (exec_ok && instr == 8'h04 && typ == `MVT_STORED_COORDINATE_TYPE && axb[7:6] == 2'b01 // [R4]
      && axb[5:0] != 6'h00 |=> move_start && move_interp && move_axes == axb[5:0])
    else $error("interpolated move wrong");

  move_pulse_a: assert property (move_start |-> move_stored_coordinate_type == val ##1 !move_start)                    // [R1]
    else $error("move start not a single pulse");

  sap_reply_a: assert property (exec_ok && instr == 8'h05 && ap_ok && axis_ok                         // [R6]
      |=> state_reg.rstatus == motion_cmd_pkg::ST_OK && state_reg.ap[axis_idx][typ[AP_W-1:0]] == val)
    else $error("axis parameter write wrong");

  direct_acc_a: assert property (exec_ok && instr == 8'h06 && !state_reg.standalone                   // [R10]
      |=> $stable(state_reg.acc))
    else $error("accumulator changed in direct mode");

  standalone_acc_a: assert property (exec_ok && instr == 8'h06 && state_reg.standalone && ap_ok       // [R9]
      && axis_ok |=> state_reg.acc == state_reg.rvalue && state_reg.rstatus == motion_cmd_pkg::ST_OK)
    else $error("accumulator not loaded in standalone mode");

  bank0_commit_a: assert property (exec_ok && instr == 8'h09 && gp_ok && axb == 8'h00                 // [R13]
      |=> nv_commit && nv_data == val && nv_index == typ ##1 !nv_commit)
    else $error("bank 0 write not committed");

  ggp_reply_a: assert property (exec_ok && instr == 8'h0A && gp_ok && bank_ok                         // [R14]
      |=> state_reg.acc == state_reg.rvalue && state_reg.rstatus == motion_cmd_pkg::ST_OK)
    else $error("global read reply wrong");

  bad_bank_a: assert property (exec_ok && instr == 8'h09 && gp_ok && !bank_ok                          // [R11]
      |=> state_reg.rstatus == motion_cmd_pkg::ST_BAD_VALUE && !nv_commit)
    else $error("invalid bank accepted");

  foreign_drop_a: assert property (exec_hit                                                          // [R15]
      && state_reg.frame[`FRM_TARGET] != state_reg.gp[0][`GP_LINK_ADDR][7:0]
      |=> $stable(state_reg.rstatus) && $stable(state_reg.rvalid) && !move_start && !nv_commit)
    else $error("frame for another address answered");

  frame_store_a: assert property (wr_en && paddr == `OFS_FRAME_BYTE && state_reg.cnt < `FRM_BODY_LEN // [R17]
      |=> state_reg.frame[$past(state_reg.cnt[2:0])] == $past(pwdata[7:0])
      && state_reg.cnt == $past(state_reg.cnt) + 4'h1)
    else $error("frame byte not stored in order");

  gap_reply_a: assert property (exec_ok && instr == motion_cmd_pkg::CMD_GET_AXIS_PARAM && ap_ok && axis_ok // [R8]
      && typ != `AP_ACTUAL_POS |=> state_reg.rvalid && state_reg.rstatus == motion_cmd_pkg::ST_OK
      && state_reg.rvalue == state_reg.ap[axis_idx][typ[AP_W-1:0]])
    else $error("axis parameter read reply wrong");

  sgp_store_a: assert property (exec_ok && instr == motion_cmd_pkg::CMD_SET_GLOBAL_PARAM && gp_ok && bank_ok // [R11]
      |=> state_reg.rstatus == motion_cmd_pkg::ST_OK && state_reg.gp[bank_idx][typ[GP_W-1:0]] == val)
    else $error("global parameter write wrong");

endmodule : motion_param_command_decoder

`default_nettype wire

// >>> testbench/host_model.sv
// host model: apb master that builds and sends command frames
`timescale 1ns/1ps
`include "motion_cmd_defines.svh"
`default_nettype none
module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one idle edge first, so back-to-back calls never assign a signal twice in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a wait
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer

  // coordinate indices are sent as given; nothing here loads the coordinates beforehand
  task automatic send_frame(input logic [7:0] tgt, ins, typ, ab, input logic [31:0] v, input logic bad);
    logic [7:0]  b [9];
    logic [31:0] rd;
    logic        er;
    b = '{tgt, ins, typ, ab, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
    if (bad) b[8] = ~b[8];
    for (int i = 0; i < 9; i++) xfer(1'b1, `OFS_FRAME_BYTE, {24'h000000, b[i]}, rd, er);
  endtask : send_frame
endmodule : host_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
`include "motion_cmd_defines.svh"
`default_nettype none
module testbench;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         move_start, move_interp, nv_commit;
  logic [7:0]   paddr, nv_index;
  logic [31:0]  pwdata, prdata, move_stored_coordinate_type, nv_data, rd;
  logic [191:0] actual_position, max_speed;
  logic [5:0]   move_axes, m_ax;
  logic         er, m_in, mv, nv, standalone;
  int           err_total, tests_run, acc, link, exp_st, exp_val, r;
  int           ax [6][16];
  int           gp [4][128];

  motion_param_command_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .actual_position(actual_position), .max_speed(max_speed), .move_start(move_start),
    .move_axes(move_axes), .move_interp(move_interp), .move_stored_coordinate_type(move_stored_coordinate_type), .nv_commit(nv_commit),
    .nv_index(nv_index), .nv_data(nv_data));
  host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // power loss is modelled by reset: all volatile state back to defaults
  task automatic model_reset();
    foreach (ax[i, j]) ax[i][j] = 0;
    foreach (gp[i, j]) gp[i][j] = 0;
    gp[0][66] = 1;
    link = 1;
    acc = 0;
    standalone = 1'b0;
  endtask : model_reset

  task automatic model(input int ins, typ, input logic [7:0] a, input logic [31:0] v);
    exp_val = 0;
    case (ins)
      4: begin
        m_ax = (a[7] | a[6]) ? a[5:0] : (a < 6 ? 6'h01 << a : 6'h00);
        m_in = a[6] & ~a[7];
        exp_st = typ != 2 ? 3 : (m_ax == 0 ? 4 : 100);
        mv = exp_st == 100;
      end
      5, 6: begin
        exp_st = typ >= 16 ? 3 : (a > 5 ? 4 : 100);
        if (exp_st == 100 && ins == 5) ax[a][typ] = v;
        if (exp_st == 100 && ins == 6) begin
          exp_val = typ == 1 ? actual_position[a*32 +: 32] : ax[a][typ];
          if (standalone) acc = exp_val;
        end
      end
      9, 10: begin
        exp_st = typ >= 128 ? 3 : ((a == 0 || a == 2 || a == 3) ? 100 : 4);
        if (exp_st == 100 && ins == 9) begin
          gp[a][typ] = v;
          nv = a == 0;
          if (a == 0 && typ == 66) link = v[7:0];
        end
        if (exp_st == 100 && ins == 10) begin
          exp_val = gp[a][typ];
          acc = exp_val;
        end
      end
      default: exp_st = 2;
    endcase
  endtask : model

  task automatic do_cmd(input int tgt, ins, typ, ab, input logic [31:0] v, input logic bad);
    logic hit;
    hit = tgt == link;
    mv = 1'b0;
    nv = 1'b0;
    exp_st = 1;
    if (hit && !bad) model(ins, typ, ab, v);
    i_host.send_frame(tgt, ins, typ, ab, v, bad);
    #1;
    check("move_start", move_start, mv);
    if (mv) begin
      check("move_axes", move_axes, m_ax);
      check("move_interp", move_interp, m_in);
      check("move_stored_coordinate_type", move_stored_coordinate_type, v);
      i_host.xfer(1'b0, `OFS_MOVE, 32'h0, rd, er);
      check("move_reg", rd, {16'h0000, v[7:0], 1'b0, m_in, m_ax});
    end
    check("nv_commit", nv_commit, nv);
    if (nv) begin
      check("nv_index", nv_index, typ[7:0]);
      check("nv_data", nv_data, v);
    end
    i_host.xfer(1'b0, `OFS_REPLY_STATUS, 32'h0, rd, er);
    if (!hit) check("reply_valid", rd[8], 1'b0);
    else check("reply_status", rd[8:0], {1'b1, exp_st[7:0]});
    i_host.xfer(1'b0, `OFS_REPLY_VALUE, 32'h0, rd, er);
    if (hit && !bad && exp_st == 100 && (ins == 6 || ins == 10)) check("reply_value", rd, exp_val);
    i_host.xfer(1'b0, `OFS_ACCUMULATOR, 32'h0, rd, er);
    check("accumulator", rd, acc);
  endtask : do_cmd

  initial begin
    #250_000;
    err_total++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    actual_position = '0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'h70b9be3e));
    model_reset();
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int g = 0; g < 6; g++) actual_position[g*32 +: 32] <= $urandom;
    i_host.xfer(1'b0, 8'h20, 32'h0, rd, er);
    check("pslverr", er, 1'b1);
    do_cmd(1, 10, 66, 0, 32'h0000_0000, 1'b0);
    do_cmd(1, 5, 4, 0, 32'd51200, 1'b0);
    check("max_speed0", max_speed[31:0], 32'd51200);
    for (int g = 0; g < 6; g++) begin
      r = $urandom;
      do_cmd(link, 5, 4, g, r, 1'b0);
      check("max_speed", max_speed[g*32 +: 32], r);
    end
    do_cmd(link, 6, 4, 3, 32'h0, 1'b0);
    do_cmd(link, 6, 1, 2, 32'h0, 1'b0);
    for (int i = 0; i < 3; i++) i_host.xfer(1'b1, `OFS_FRAME_BYTE, 32'h0000_00A5, rd, er);
    i_host.xfer(1'b0, `OFS_FRAME_BYTE, 32'h0, rd, er);
    check("frame_count", rd, 32'h0000_0003);
    i_host.xfer(1'b1, `OFS_CONTROL, 32'h0000_0003, rd, er);
    i_host.xfer(1'b0, `OFS_CONTROL, 32'h0, rd, er);
    check("control", rd, 32'h0000_0001);
    standalone = 1'b1;
    do_cmd(link, 6, 4, 5, 32'h0, 1'b0);
    for (int b = 0; b < 4; b++) do_cmd(link, 9, 7, b, $urandom, 1'b0);
    for (int b = 0; b < 4; b++) do_cmd(link, 10, 7, b, $urandom, 1'b0);
    do_cmd(link, 5, 16, 0, 32'h5, 1'b0);
    do_cmd(link, 6, 4, 6, 32'h0, 1'b0);
    do_cmd(link, 7, 0, 0, 32'h0, 1'b0);
    do_cmd(link, 4, 2, 4, 32'd8, 1'b0);
    do_cmd(link, 4, 2, 8'h85, 32'd5, 1'b0);
    do_cmd(link, 4, 2, 8'h47, 32'd2, 1'b0);
    do_cmd(link, 4, 2, 8'hC3, 32'd9, 1'b0);
    do_cmd(link, 4, 2, 6, 32'd1, 1'b0);
    do_cmd(link, 4, 2, 8'h80, 32'd1, 1'b0);
    do_cmd(link, 4, 1, 0, 32'd1, 1'b0);
    do_cmd(link, 5, 4, 0, 32'd7, 1'b1);
    do_cmd(link, 6, 4, 0, 32'h0, 1'b0);
    do_cmd(link, 9, 66, 0, 32'd3, 1'b0);
    do_cmd(1, 5, 4, 0, 32'd9, 1'b0);
    do_cmd(3, 6, 4, 0, 32'h0, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    model_reset();
    #1;
    check("max_speed_rst", max_speed[31:0], 32'h0);
    do_cmd(1, 6, 4, 0, 32'h0, 1'b0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
